/* core/pcs_consts.vh */
// Constants for the program counter, return stack and indirect addressing block.
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus.
`define PCS_OFF_INDIRECT   8'h00
`define PCS_OFF_PC_LOW     8'h04
`define PCS_OFF_STATUS     8'h08
`define PCS_OFF_FILE_PTR   8'h0C
`define PCS_OFF_LATCH      8'h10
`define PCS_OFF_PC         8'h14
`define PCS_OFF_EFF_ADDR   8'h18

// Widths and field positions.
`define PCS_PC_W           13
`define PCS_LATCH_W        5
`define PCS_CALL_TGT_W     11
`define PCS_BANK_BIT       7
`define PCS_EFF_W          9
`define PCS_STACK_DEPTH    8
`define PCS_SP_W           3

// Pointer value that names the indirect port itself.
`define PCS_INDIRECT_SELF  8'h00

// Reset values.
`define PCS_PC_RST         13'h0000
`define PCS_LATCH_RST      5'h00
`define PCS_FPTR_RST       8'h00
`define PCS_BANK_RST       1'b0
`define PCS_SP_RST         3'h0

// Interrupt vector address.
`define PCS_IRQ_VECTOR     13'h0004

// AXI responses.
`define PCS_RESP_OKAY      2'h0
`define PCS_RESP_DECERR    2'h3

`endif

/* core/pcs_core.v */
// Program counter, circular return stack and indirect data path with AXI4-Lite access.
`timescale 1ns/1ps
`include "pcs_consts.vh"


module pcs_core #(
    parameter DATA_DEPTH = 512
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        op_advance,
    input  wire        op_call,
    input  wire        op_goto,
    input  wire [10:0] op_target,
    input  wire        op_return,
    input  wire        op_irq_vector,
    input  wire        op_add_low,
    input  wire [7:0]  op_offset,
    output reg  [12:0] pc,
    output wire [8:0]  eff_addr
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    reg  [4:0]  pc_high_latch;
    reg  [7:0]  file_pointer_reg;
    reg         indirect_bank_select;
    reg  [12:0] stack_mem [0:`PCS_STACK_DEPTH-1];
    reg  [2:0]  stack_ptr;
    reg  [7:0]  data_mem [0:DATA_DEPTH-1];

    reg         aw_held;
    reg  [7:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    wire        core_op;
    wire        wr_go;
    wire        wr_lane0;
    wire        ind_self;
    wire [7:0]  ind_rd;
    wire [2:0]  pop_ptr;
    reg  [12:0] next_pc;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;
    reg         wr_hit;

    assign eff_addr = {indirect_bank_select, file_pointer_reg};
    assign ind_self = (file_pointer_reg == `PCS_INDIRECT_SELF);
    assign ind_rd   = ind_self ? 8'h00 : data_mem[eff_addr];
    assign pop_ptr  = stack_ptr - 3'h1;

    assign core_op = op_advance | op_call | op_goto | op_return | op_irq_vector | op_add_low;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side. Address and data are caught separately in either
    // order; the write is performed once both are held. A core operation in the
    // same cycle holds the write off, so no update of the PC is ever lost.

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign wr_go         = aw_held & w_held & ~s_axi_bvalid & ~core_op;
    assign wr_lane0      = wr_go & w_strb[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `PCS_RESP_OKAY : `PCS_RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        wr_hit = 1'b1;
        if (aw_addr == `PCS_OFF_INDIRECT) begin
            wr_hit = 1'b1;
        end else if (aw_addr == `PCS_OFF_PC_LOW) begin
            wr_hit = 1'b1;
        end else if (aw_addr == `PCS_OFF_STATUS) begin
            wr_hit = 1'b1;
        end else if (aw_addr == `PCS_OFF_FILE_PTR) begin
            wr_hit = 1'b1;
        end else if (aw_addr == `PCS_OFF_LATCH) begin
            wr_hit = 1'b1;
        end else if (aw_addr == `PCS_OFF_EFF_ADDR) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software-visible control registers. No stack action touches the latch.

    always @(posedge aclk) begin
        if (!aresetn) begin
            pc_high_latch        <= `PCS_LATCH_RST;
            file_pointer_reg     <= `PCS_FPTR_RST;
            indirect_bank_select <= `PCS_BANK_RST;
        end else if (wr_lane0) begin
            if (aw_addr == `PCS_OFF_LATCH) begin
                pc_high_latch <= w_data[4:0];
            end else if (aw_addr == `PCS_OFF_FILE_PTR) begin
                file_pointer_reg <= w_data[7:0];
            end else if (aw_addr == `PCS_OFF_STATUS) begin
                indirect_bank_select <= w_data[`PCS_BANK_BIT];
            end
        end
    end

    // Data memory behind the indirect port; it has no reset of its own.
    always @(posedge aclk) begin
        if (wr_lane0 && aw_addr == `PCS_OFF_INDIRECT && !ind_self) begin
            data_mem[eff_addr] <= w_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter. Core operations are taken in the order call and goto,
    // interrupt, return, computed jump, advance; the core asserts one at a time.

    always @* begin
        next_pc = pc;
        if (op_call || op_goto) begin
            next_pc = {pc_high_latch[4:3], op_target};
        end else if (op_irq_vector) begin
            next_pc = `PCS_IRQ_VECTOR;
        end else if (op_return) begin
            next_pc = stack_mem[pop_ptr];
        end else if (op_add_low) begin
            next_pc = {pc_high_latch, pc[7:0] + op_offset};
        end else if (op_advance) begin
            next_pc = pc + 13'h0001;
        end else if (wr_lane0 && aw_addr == `PCS_OFF_PC_LOW) begin
            next_pc = {pc_high_latch, w_data[7:0]};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            pc <= `PCS_PC_RST;
        end else begin
            pc <= next_pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Return stack. The pointer wraps modulo eight with no flag, so a ninth push
    // overwrites the oldest entry and an extra pop simply reads a stale one.

    always @(posedge aclk) begin
        if (!aresetn) begin
            stack_ptr <= `PCS_SP_RST;
        end else if (op_call || op_irq_vector) begin
            stack_ptr <= stack_ptr + 3'h1;
        end else if (op_return) begin
            stack_ptr <= pop_ptr;
        end
    end

    always @(posedge aclk) begin
        if (op_call) begin
            stack_mem[stack_ptr] <= pc + 13'h0001;
        end else if (op_irq_vector) begin
            stack_mem[stack_ptr] <= pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side. One read at a time; the stack pointer has no address,
    // and the upper PC bits are never readable, so the full PC has no address either.

    assign s_axi_arready = ~s_axi_rvalid;

    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp = `PCS_RESP_OKAY;
        if (s_axi_araddr == `PCS_OFF_INDIRECT) begin
            next_rdata = {24'h000000, ind_rd};
        end else if (s_axi_araddr == `PCS_OFF_PC_LOW) begin
            next_rdata = {24'h000000, pc[7:0]};
        end else if (s_axi_araddr == `PCS_OFF_STATUS) begin
            next_rdata = {24'h000000, indirect_bank_select, 7'h00};
        end else if (s_axi_araddr == `PCS_OFF_FILE_PTR) begin
            next_rdata = {24'h000000, file_pointer_reg};
        end else if (s_axi_araddr == `PCS_OFF_LATCH) begin
            next_rdata = {27'h0000000, pc_high_latch};
        end else if (s_axi_araddr == `PCS_OFF_EFF_ADDR) begin
            next_rdata = {23'h000000, eff_addr};
        end else begin
            next_rresp = `PCS_RESP_DECERR;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PCS_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* verif/pcs_core_sva.sv */
// Checker for the program counter and return stack ports.
`timescale 1ns/1ps
module pcs_core_sva (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        op_advance,
    input wire        op_call,
    input wire        op_goto,
    input wire [10:0] op_target,
    input wire        op_return,
    input wire        op_irq_vector,
    input wire        op_add_low,
    input wire [7:0]  op_offset,
    input wire [12:0] pc
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire jump = op_call || op_goto;
    wire high = jump || op_irq_vector || op_return;
    ////////////////////////////////////////////////////////////////////////////
    a_reset_pc: assert property (disable iff (1'b0) !aresetn |=> pc == 13'h0000)
        else $error("pc not cleared by reset");
    a_goto_target: assert property (op_goto |=> pc[10:0] == $past(op_target))
        else $error("goto target not loaded");
    a_call_target: assert property (op_call |=> pc[10:0] == $past(op_target))
        else $error("call target not loaded");
    a_irq_vector: assert property (op_irq_vector && !jump |=> pc == 13'h0004)
        else $error("interrupt vector not taken");
    a_add_low: assert property (op_add_low && !high |=> pc[7:0] == $past(pc[7:0]) + $past(op_offset))
        else $error("computed branch wrong");
    a_advance_inc: assert property (op_advance && !high && !op_add_low |=> pc == $past(pc) + 13'h1)
        else $error("pc did not advance");
    a_call_return: assert property ((op_call && !op_goto) ##1 (op_return && !jump && !op_irq_vector) |=> pc == $past(pc, 2) + 13'h1)
        else $error("return address wrong");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
endmodule
bind pcs_core pcs_core_sva i_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .op_advance(op_advance),
    .op_call(op_call), .op_goto(op_goto), .op_target(op_target), .op_return(op_return),
    .op_irq_vector(op_irq_vector), .op_add_low(op_add_low), .op_offset(op_offset), .pc(pc));

/* verif/pcs_core_tb.sv */
// Self-checking testbench for the program counter block.
`timescale 1ns/1ps
`include "pcs_consts.vh"
module pcs_core_tb;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] awa = 0, ara = 0, off = 0;
    logic [31:0] wd = 0;
    logic [10:0] tgt = 0;
    logic [5:0] ops = 0;
    wire awr, wr_, brv, arr, rv;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [12:0] pc;
    wire [8:0] ea;
    logic [33:0] q[$];
    logic [12:0] pq[$];
    logic [12:0] m_pc, stk[8];
    logic [4:0] lat;
    logic [2:0] sp;
    integer errors = 0, tests_run = 0, seed = 32'h8433, i;
    always #10 aclk = ~aclk;
    pcs_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(brv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .op_advance(ops[0]),
        .op_call(ops[1]), .op_goto(ops[2]), .op_target(tgt), .op_return(ops[3]),
        .op_irq_vector(ops[4]), .op_add_low(ops[5]), .op_offset(off), .pc(pc), .eff_addr(ea));
    ////////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Each wait is bounded so a stuck handshake ends the run instead of hanging it.
    task wt(input int w);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
            if (n > 50) begin
                errors++;
                stop_test;
            end
        end while (!(w == 0 ? awr && wr_ : w == 1 ? brv : w == 2 ? arr : rv));
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        q.push_back({r, 32'h0});
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1;
        wt(0);
        @(posedge aclk);
        awv <= 0; wv <= 0; bry <= 1;
        wt(1);
        @(posedge aclk);
        bry <= 0;
    endtask
    task rd(input [7:0] a, input [31:0] d, input [1:0] r);
        q.push_back({r, d});
        @(posedge aclk);
        ara <= a; arv <= 1;
        wt(2);
        @(posedge aclk);
        arv <= 0; rry <= 1;
        wt(3);
        @(posedge aclk);
        rry <= 0;
    endtask
    // Kind 6 is a call followed at once by a return, so the pushed address is popped next cycle.
    task op(input int k);
        @(posedge aclk);
        ops <= (k == 6) ? 6'h02 : 6'h01 << k;
        tgt <= $random(seed);
        off <= $random(seed);
        if (k == 6) begin
            @(posedge aclk);
            ops <= 6'h08;
        end
        @(posedge aclk);
        ops <= 0;
        case (k)
            0: m_pc = m_pc + 13'h1;
            1: begin stk[sp] = m_pc + 13'h1; sp++; m_pc = {lat[4:3], tgt}; end
            2: m_pc = {lat[4:3], tgt};
            3: begin sp--; m_pc = stk[sp]; end
            4: begin stk[sp] = m_pc; sp++; m_pc = 13'h0004; end
            5: m_pc = {lat, m_pc[7:0] + off};
            6: begin stk[sp] = m_pc + 13'h1; m_pc = stk[sp]; end
        endcase
        pq.push_back(m_pc);
    endtask
    always @(posedge aclk) begin
        if (rv && rry && ara == `PCS_OFF_EFF_ADDR) chk("eff_addr", {25'h0, ea}, q[0]);
        if (rv && rry) chk("read", {rr, rdat}, q.pop_front());
        if (brv && bry) chk("write", {br, 32'h0}, q.pop_front());
    end
    always @(negedge aclk) begin
        if (pq.size() > 0) chk("pc", {21'h0, pc}, pq.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        m_pc = 0; sp = 0; lat = 5'h1B;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        pq.push_back(13'h0000);
        rd(`PCS_OFF_PC, 0, 3);
        wr(`PCS_OFF_LATCH, lat, 0);
        wr(`PCS_OFF_PC_LOW, 32'h5A, 0);
        m_pc = {lat, 8'h5A};
        pq.push_back(m_pc);
        rd(`PCS_OFF_PC_LOW, 32'h5A, 0);
        for (i = 0; i < 36; i++) begin
            op(i < 6 ? i % 3 : i < 16 ? 1 : i == 16 ? 4 : i < 28 ? 3 : i == 35 ? 6 : 5);
        end
        rd(`PCS_OFF_LATCH, lat, 0);
        wr(`PCS_OFF_STATUS, 32'h80, 0);
        wr(`PCS_OFF_FILE_PTR, 32'h35, 0);
        rd(`PCS_OFF_EFF_ADDR, 32'h135, 0);
        wr(`PCS_OFF_INDIRECT, 32'hA5, 0);
        rd(`PCS_OFF_INDIRECT, 32'hA5, 0);
        wr(`PCS_OFF_FILE_PTR, 0, 0);
        wr(`PCS_OFF_INDIRECT, 32'h77, 0);
        rd(`PCS_OFF_INDIRECT, 0, 0);
        rd(`PCS_OFF_EFF_ADDR, 32'h100, 0);
        wr(`PCS_OFF_FILE_PTR, 32'h35, 0);
        rd(`PCS_OFF_INDIRECT, 32'hA5, 0);
        rd(8'h40, 0, 3);
        wr(8'h40, 1, 3);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        pq.push_back(13'h0000);
        repeat (2) @(posedge aclk);
        stop_test;
    end
endmodule
